// File: hw/bes_env_select.sv
// Boot environment select: strap capture, region decode, port allocation,
// base-memory wait states, bus-status monitor and clock-output gating.
// Assumes one 100 MHz clock, inputs synchronous to it, and a register
// master that never waits and reads data one cycle after the strobe.
//
// The implementer's own choices: strobed register access and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "bes_consts.svh"

// Summary of operation
// RULE_01: Straps sampled at power-up pick ROM, external boot or development.
// RULE_02: ROM environment fetches from on-chip boot ROM after any reset.
// RULE_03: On-chip boot region is read-only and at most 2 Kbytes.
// RULE_04: Finishing boot hands execution to the external application memory.
// RULE_05: Invalid external code leaves the host free to reprogram the flash.
// RULE_06: External boot replaces the on-chip region with up to 64 Kbytes.
// RULE_07: External boot gives sixth and seventh ports to the base memory.
// RULE_08: Development gives sixth to eighth ports to base, emulator, status.
// RULE_09: Development tools load base and application images into RAM.
// RULE_10: Base-memory wait states are programmable, same count everywhere.
// RULE_11: On-chip and off-chip base accesses take identical cycle counts.
// RULE_12: External data path is selectable as 8 or 16 bits.
// RULE_13: Application region is selectable as 32 or 56 Kbytes.
// RULE_14: Development shows external cycles, internal ones too when visible.
// RULE_15: Core clock output in external boot and development, in ROM only if enabled.
// RULE_16: Host device strap sets host devices enabled after every reset.
// RULE_17: Outside logic must not pull upper address lines high at power-up.
// RULE_18: Master-reset pin never resamples the straps.
// RULE_19: Watchdog reset redoes power-up actions but keeps the strap latch.
// RULE_20: Decoded environment is latched only by power-up reset.
module bes_env_select
    import bes_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic masterResetPin,
    input wire logic watchdogReset,
    input wire logic [1:0] environmentSelectStraps,
    input wire logic hostDeviceDefaultEnable,
    input wire logic pnpEnable,
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdData,
    input wire logic [16:0] fetchAddr,
    input wire logic baseAccessStart,
    output logic baseAccessDone,
    input wire logic busCycleValid,
    input wire logic busCycleExternal,
    input wire logic [2:0] busCycleStatusIn,
    output logic [2:0] busCycleStatus,
    output logic selOnChipRom,
    output logic selBaseMem,
    output logic selAppMem,
    output logic bootFromRom,
    output logic runApplication,
    output logic hostReprogram,
    output logic bus16,
    output bes_pins_t pinAlloc,
    output logic coreClockOutEnable,
    output logic hostDevicesEnabled
);

    // ************************************************************
    // Register decode helper
    // ************************************************************
    function automatic logic regHit(input logic [7:0] a,
                                    input logic [7:0] ofs);
        regHit = (a == ofs);
    endfunction

    // ************************************************************
    // Reset release and soft resets
    // ************************************************************
    logic rstMeta_r;
    logic rstnSync_r;
    logic mrPinDly_r;
    logic softReset;

    // Release power-up reset through two flops; assert straight away
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rstMeta_r <= 1'b0;
            rstnSync_r <= 1'b0;
        end else begin
            rstMeta_r <= 1'b1;
            rstnSync_r <= rstMeta_r;
        end
    end

    // Rising edge on the master-reset pin is the warm reset trigger
    always_ff @(posedge clk or negedge rstnSync_r) begin
        if (!rstnSync_r) begin
            mrPinDly_r <= 1'b0;
        end else begin
            mrPinDly_r <= masterResetPin;
        end
    end

    // Warm and watchdog resets share one path; neither touches the straps
    assign softReset = (masterResetPin & ~mrPinDly_r) | watchdogReset;

    // ************************************************************
    // Strap latch
    // ************************************************************
    logic captured_r;
    bes_env_t env_r;
    bes_env_t envDecoded;
    logic hdStrap_r;

    // Low pattern is the ROM environment so it needs no pull-ups
    assign envDecoded =
        (environmentSelectStraps == `BES_STRAP_IRE) ? BES_ENV_ROM :
        (environmentSelectStraps == `BES_STRAP_IRD) ? BES_ENV_EXTBOOT :
        BES_ENV_DEV; // RULE_01

    // Straps caught once on the first edge after release, never again
    always_ff @(posedge clk or negedge rstnSync_r) begin
        if (!rstnSync_r) begin
            captured_r <= 1'b0;
            env_r <= BES_ENV_ROM;
            hdStrap_r <= 1'b0;
        end else if (!captured_r) begin
            captured_r <= 1'b1; // RULE_20
            env_r <= envDecoded; // RULE_01
            hdStrap_r <= hostDeviceDefaultEnable; // RULE_16
        end
    end
    // softReset is not a term above: RULE_18 RULE_19

    // ************************************************************
    // Register port
    // ************************************************************
    bes_ctrl_t ctrl_r;
    bes_ctrl_t ctrlWr;
    logic ctrlWrEn;
    logic bootWrEn;
    logic [31:0] statWord;
    logic [31:0] rdMux;

    assign ctrlWr = bes_ctrl_t'(regWrData[`BES_CTRL_CLKOE:0]);
    assign ctrlWrEn = regWr & regHit(regAddr, `BES_CTRL_OFS);
    assign bootWrEn = regWr & regHit(regAddr, `BES_BOOT_OFS);

    // Soft reset reloads defaults; a write in the same cycle loses
    always_ff @(posedge clk or negedge rstnSync_r) begin
        if (!rstnSync_r) begin
            ctrl_r <= bes_ctrl_t'(`BES_CTRL_RST);
        end else if (softReset) begin
            ctrl_r <= bes_ctrl_t'(`BES_CTRL_RST); // RULE_19
        end else if (ctrlWrEn) begin
            ctrl_r <= ctrlWr; // RULE_10 RULE_12 RULE_13
        end
    end

    // ************************************************************
    // Boot sequence
    // ************************************************************
    bes_boot_t boot_r;
    bes_boot_t boot_nxt;
    logic finishCmd;
    logic codeValid;

    assign finishCmd = bootWrEn & regWrData[`BES_BOOT_FINISH];
    assign codeValid = regWrData[`BES_BOOT_VALID];

    // Boot code reports the validity check when it finishes
    always_comb begin
        boot_nxt = boot_r;
        unique case (boot_r)
            BES_ST_BOOT: begin
                if (finishCmd) begin
                    boot_nxt = codeValid ? BES_ST_APP // RULE_04
                                         : BES_ST_HOSTPROG; // RULE_05
                end
            end
            BES_ST_APP: boot_nxt = BES_ST_APP;
            BES_ST_HOSTPROG: begin
                if (finishCmd && codeValid) begin
                    boot_nxt = BES_ST_APP;
                end
            end
        endcase
    end

    // Any reset restarts from the boot region
    always_ff @(posedge clk or negedge rstnSync_r) begin
        if (!rstnSync_r) begin
            boot_r <= BES_ST_BOOT;
        end else if (softReset) begin
            boot_r <= BES_ST_BOOT; // RULE_02
        end else begin
            boot_r <= boot_nxt;
        end
    end

    // ************************************************************
    // Region decode
    // ************************************************************
    logic romEnv;
    logic devEnv;
    logic inBaseZone;
    logic romHit;
    logic baseHit;
    logic appHit;
    logic [16:0] appLimit;

    assign romEnv = (env_r == BES_ENV_ROM);
    assign devEnv = (env_r == BES_ENV_DEV);
    assign inBaseZone = ~fetchAddr[16];
    // Addresses past 2K in the ROM window decode to nothing
    assign romHit = romEnv & inBaseZone &
                    (fetchAddr < `BES_ROM_BYTES); // RULE_03
    assign baseHit = ~romEnv & inBaseZone; // RULE_06
    assign appLimit = ctrl_r.app56k ? `BES_APP56_BYTES
                                    : `BES_APP32_BYTES; // RULE_13
    assign appHit = fetchAddr[16] &
                    ({1'b0, fetchAddr[15:0]} < appLimit);

    // ************************************************************
    // Base-memory wait states
    // ************************************************************
    logic wsBusy_r;
    logic [3:0] wsCnt_r;
    logic wsStart;

    // Starts while busy are ignored; the core never overlaps them
    assign wsStart = baseAccessStart & ~wsBusy_r;

    // Same count for on-chip and off-chip so timing never differs
    always_ff @(posedge clk or negedge rstnSync_r) begin
        if (!rstnSync_r) begin
            wsBusy_r <= 1'b0;
            wsCnt_r <= 4'h0;
            baseAccessDone <= 1'b0;
        end else begin
            baseAccessDone <= wsBusy_r & (wsCnt_r == 4'h0); // RULE_11
            if (wsStart) begin
                wsBusy_r <= 1'b1;
                wsCnt_r <= ctrl_r.waitStates; // RULE_10
            end else if (wsBusy_r) begin
                if (wsCnt_r == 4'h0) begin
                    wsBusy_r <= 1'b0;
                end else begin
                    wsCnt_r <= wsCnt_r - 4'h1;
                end
            end
        end
    end

    // ************************************************************
    // Host device enable
    // ************************************************************
    // Every reset returns to the strap default; PnP may turn it on
    always_ff @(posedge clk or negedge rstnSync_r) begin
        if (!rstnSync_r) begin
            hostDevicesEnabled <= 1'b0;
        end else if (!captured_r) begin
            hostDevicesEnabled <= hostDeviceDefaultEnable; // RULE_16
        end else if (softReset) begin
            hostDevicesEnabled <= hdStrap_r; // RULE_16
        end else if (pnpEnable) begin
            hostDevicesEnabled <= 1'b1;
        end
    end

    // ************************************************************
    // Status word and read data
    // ************************************************************
    assign statWord = {26'h000_0000,
                       boot_r,
                       hostDevicesEnabled,
                       hdStrap_r,
                       env_r};
    assign rdMux = regHit(regAddr, `BES_CTRL_OFS) ?
                       {24'h00_0000, ctrl_r} :
                   regHit(regAddr, `BES_STAT_OFS) ? statWord :
                   32'h0000_0000;

    // Read data stands for one cycle only, zero otherwise
    always_ff @(posedge clk or negedge rstnSync_r) begin
        if (!rstnSync_r) begin
            regRdData <= 32'h0000_0000;
        end else begin
            regRdData <= regRd ? rdMux : 32'h0000_0000;
        end
    end

    // ************************************************************
    // Registered pin-side outputs
    // ************************************************************
    logic showCycle;

    // Status lines idle at zero outside development or after reset
    assign showCycle = devEnv & busCycleValid &
        (busCycleExternal | ctrl_r.internalCycleVisibility); // RULE_14

    always_ff @(posedge clk or negedge rstnSync_r) begin
        if (!rstnSync_r) begin
            busCycleStatus <= 3'h0;
            selOnChipRom <= 1'b0;
            selBaseMem <= 1'b0;
            selAppMem <= 1'b0;
            bootFromRom <= 1'b0;
            runApplication <= 1'b0;
            hostReprogram <= 1'b0;
            bus16 <= 1'b0;
            pinAlloc <= '0;
            coreClockOutEnable <= 1'b0;
        end else begin
            busCycleStatus <= (showCycle & ~softReset) ?
                              busCycleStatusIn : 3'h0; // RULE_14
            selOnChipRom <= romHit; // RULE_02 RULE_03
            selBaseMem <= baseHit; // RULE_06
            selAppMem <= appHit; // RULE_04
            bootFromRom <= romEnv & (boot_r == BES_ST_BOOT); // RULE_02
            runApplication <= (boot_r == BES_ST_APP); // RULE_04
            hostReprogram <= (boot_r == BES_ST_HOSTPROG); // RULE_05
            bus16 <= ctrl_r.bus16; // RULE_12
            pinAlloc.sixthToBaseMem <= ~romEnv; // RULE_07 RULE_08
            pinAlloc.seventhToBaseMem <= ~romEnv; // RULE_07 RULE_08
            pinAlloc.eighthToDevSignals <= devEnv; // RULE_08
            coreClockOutEnable <= ~romEnv |
                                  ctrl_r.clockOutputEnable; // RULE_15
        end
    end

endmodule
`default_nettype wire

// File: include/bes_consts.svh
// Constants for the boot environment select block.
// Assumes byte addresses on the register port and a 100 MHz core clock.
`ifndef BES_CONSTS_SVH
`define BES_CONSTS_SVH

// Register byte offsets
`define BES_CTRL_OFS 8'h00
`define BES_STAT_OFS 8'h04
`define BES_BOOT_OFS 8'h08

// Control register fields
`define BES_CTRL_WS_LSB 0
`define BES_CTRL_WS_MSB 3
`define BES_CTRL_BUS16 4
`define BES_CTRL_APP56 5
`define BES_CTRL_CYCVIS 6
`define BES_CTRL_CLKOE 7
`define BES_CTRL_RST 8'h00

// Boot command fields
`define BES_BOOT_FINISH 0
`define BES_BOOT_VALID 1

// Status register fields
`define BES_STAT_ENV_LSB 0
`define BES_STAT_HDSTRAP 2
`define BES_STAT_HOST_DEVICE_DEFAULT_ENABLE 3
`define BES_STAT_BST_LSB 4

// Memory sizes in bytes
`define BES_ROM_BYTES 17'h0_0800
`define BES_APP32_BYTES 17'h0_8000
`define BES_APP56_BYTES 17'h0_E000

// Strap patterns
`define BES_STRAP_IRE 2'h0
`define BES_STRAP_IRD 2'h1

// Clock period in ns
`define BES_CLK_NS 10

`endif

// File: include/bes_pkg.sv
// Types for the boot environment select block.
// Assumes bes_consts.svh is on the include path.
package bes_pkg;

    // Operating environment chosen by the straps
    typedef enum logic [1:0] {
        BES_ENV_ROM,
        BES_ENV_EXTBOOT,
        BES_ENV_DEV
    } bes_env_t;

    // Boot sequence state
    typedef enum logic [1:0] {
        BES_ST_BOOT,
        BES_ST_APP,
        BES_ST_HOSTPROG
    } bes_boot_t;

    // Software control word
    typedef struct packed {
        logic clockOutputEnable;
        logic internalCycleVisibility;
        logic app56k;
        logic bus16;
        logic [3:0] waitStates;
    } bes_ctrl_t;

    // Pin allocation of the shared ports
    typedef struct packed {
        logic sixthToBaseMem;
        logic seventhToBaseMem;
        logic eighthToDevSignals;
    } bes_pins_t;

endpackage

// File: tb/bes_dev_tools.sv
// Development tool model: produces core bus cycles for the status monitor.
// Assumes the bench advances the random word once per clock.
`timescale 1ns/10ps
`default_nettype none
module bes_dev_tools (
    input wire logic clk,
    input wire logic run,
    input wire logic [31:0] rnd,
    output logic cycValid,
    output logic cycExternal,
    output logic [2:0] cycStatus
);
    // ****************************************
    // Bus cycle source
    // ****************************************
    // Idle status toggles so stale values can never look right
    always @(posedge clk) begin
        cycValid <= run & rnd[0];
        cycExternal <= rnd[1];
        cycStatus <= run ? rnd[4:2] : ~cycStatus;
    end
    initial cycStatus = 3'h0;
endmodule
`default_nettype wire

// File: tb/bes_env_select_asserts.sv
// Checker for the boot environment select block, bound to its top module.
// Assumes it sees only the top ports and one clock domain.
`timescale 1ns/10ps
`default_nettype none
module bes_env_select_asserts
    import bes_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic masterResetPin,
    input wire logic watchdogReset,
    input wire logic pnpEnable,
    input wire logic busCycleValid,
    input wire logic busCycleExternal,
    input wire logic [2:0] busCycleStatusIn,
    input wire logic [2:0] busCycleStatus,
    input wire logic baseAccessDone,
    input wire bes_pins_t pinAlloc,
    input wire logic coreClockOutEnable,
    input wire logic hostDevicesEnabled,
    input wire logic runApplication,
    input wire logic hostReprogram
);
    // ****************************************
    // Properties
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    // Soft resets zero the status lines, so they are kept out of the cause
    AST_BST_SHOW: assert property (pinAlloc.eighthToDevSignals &&
        busCycleValid && busCycleExternal && !watchdogReset && !masterResetPin
        |=> busCycleStatus == $past(busCycleStatusIn))
        else $error("bus status not shown");
    AST_BST_IDLE: assert property (!busCycleValid
        |=> busCycleStatus == 3'h0) else $error("bus status without cycle");
    AST_PORT_PAIR: assert property (pinAlloc.sixthToBaseMem ==
        pinAlloc.seventhToBaseMem) else $error("port pair split");
    AST_DEV_PORTS: assert property (pinAlloc.eighthToDevSignals
        |-> pinAlloc.sixthToBaseMem) else $error("dev ports incomplete");
    AST_CLK_OUT: assert property (pinAlloc.sixthToBaseMem &&
        $past(pinAlloc.sixthToBaseMem) |-> coreClockOutEnable)
        else $error("clock output off");
    AST_ENV_HOLD: assert property ((pinAlloc != 3'h0)
        |=> pinAlloc == $past(pinAlloc)) else $error("environment moved");
    AST_PNP_EN: assert property (pnpEnable && !watchdogReset &&
        !masterResetPin |=> hostDevicesEnabled) else $error("pnp ignored");
    AST_BOOT_EXCL: assert property (!(runApplication &&
        hostReprogram)) else $error("run and reprogram together");
    AST_DONE_PULSE: assert property (baseAccessDone
        |=> !baseAccessDone) else $error("done longer than a cycle");
endmodule

bind bes_env_select bes_env_select_asserts chk_u (.clk, .resetn,
    .masterResetPin, .watchdogReset, .pnpEnable, .busCycleValid,
    .busCycleExternal, .busCycleStatusIn, .busCycleStatus, .baseAccessDone,
    .pinAlloc, .coreClockOutEnable, .hostDevicesEnabled, .runApplication,
    .hostReprogram);
`default_nettype wire

// File: tb/boot_environment_select_test.sv
// Testbench for the boot environment select block.
// Assumes the checker is bound from its own file.
`timescale 1ns/10ps
`default_nettype none
`include "bes_consts.svh"
module boot_environment_select_test;
    import bes_pkg::*;
    logic clk = 0, resetn = 0, masterResetPin = 0, watchdogReset = 0;
    logic [1:0] straps = 0;
    logic hdStrap = 0, pnpEnable = 0, regWr = 0, regRd = 0, rdPend = 0;
    logic [7:0] regAddr = 0;
    logic [31:0] regWrData = 0, regRdData, rnd = 32'h5ec7;
    logic [16:0] fetchAddr = 0;
    logic baseAccessStart = 0, baseAccessDone, cycValid, cycExternal, run = 0;
    logic [2:0] cycStatus, busCycleStatus;
    logic selRom, selBase, selApp, bootFromRom, runApp, hostReprog, bus16;
    logic clkOut, hostEn, stOn = 0, vis = 0;
    bes_pins_t pinAlloc;
    logic [1:0] env = 0;
    logic [31:0] rdQ[$], stQ[$];
    int fail_count = 0, total_checks = 0, cycles = 0, n;
    logic [3:0] ws;
    logic [7:0] ctrl;

    always #5 clk = ~clk;

    bes_env_select dut_u (.clk(clk), .resetn(resetn),
        .masterResetPin(masterResetPin), .watchdogReset(watchdogReset),
        .environmentSelectStraps(straps), .hostDeviceDefaultEnable(hdStrap),
        .pnpEnable(pnpEnable), .regAddr(regAddr), .regWrData(regWrData),
        .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
        .fetchAddr(fetchAddr), .baseAccessStart(baseAccessStart),
        .baseAccessDone(baseAccessDone), .busCycleValid(cycValid),
        .busCycleExternal(cycExternal), .busCycleStatusIn(cycStatus),
        .busCycleStatus(busCycleStatus), .selOnChipRom(selRom),
        .selBaseMem(selBase), .selAppMem(selApp), .bootFromRom(bootFromRom),
        .runApplication(runApp), .hostReprogram(hostReprog), .bus16(bus16),
        .pinAlloc(pinAlloc), .coreClockOutEnable(clkOut),
        .hostDevicesEnabled(hostEn));
    bes_dev_tools tools_u (.clk(clk), .run(run), .rnd(rnd),
        .cycValid(cycValid), .cycExternal(cycExternal), .cycStatus(cycStatus));

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task automatic check(input string what, input logic [31:0] seen, exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        regAddr <= a;
        regWrData <= d;
        regWr <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
    endtask
    // Expected value is queued; the monitor compares it two cycles later
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        regAddr <= a;
        regRd <= 1'b1;
        rdQ.push_back(e);
        @(posedge clk);
        regRd <= 1'b0;
    endtask
    // One-cycle pulse: 0 plug-and-play, 1 watchdog, 2 master-reset pin
    task automatic pulse(input int k);
        @(posedge clk);
        if (k == 0) pnpEnable <= 1'b1;
        else if (k == 1) watchdogReset <= 1'b1;
        else masterResetPin <= 1'b1;
        @(posedge clk);
        pnpEnable <= 1'b0;
        watchdogReset <= 1'b0;
        masterResetPin <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // ****************************************
    // Monitor and timeout
    // ****************************************
    // Status lags its inputs by one cycle, so expectations queue for one edge
    always @(posedge clk) begin
        rnd <= lfsr(rnd);
        if (rdPend) check("regRdData", regRdData, rdQ.pop_front());
        rdPend <= regRd;
        if (stOn && stQ.size() > 0) begin
            check("busCycleStatus", {29'h0, busCycleStatus},
                stQ.pop_front());
        end
        if (stOn) begin
            stQ.push_back((env == 2'h2 && cycValid && (cycExternal || vis)) ?
                {29'h0, cycStatus} : 32'h0);
        end
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            test_done();
        end
    end

    // ****************************************
    // Main sequence, one power-up per strap pattern
    // ****************************************
    initial begin
        for (int s = 0; s < 4; s++) begin
            resetn <= 1'b0;
            // Upper address bit held low through power-up
            fetchAddr <= 17'h0_0000;
            straps <= s[1:0];
            hdStrap <= s[0];
            env <= (s > 1) ? 2'h2 : s[1:0];
            repeat (6) @(posedge clk);
            resetn <= 1'b1;
            repeat (4) @(posedge clk);
            #1;
            rd(`BES_STAT_OFS, {28'h0, hdStrap, hdStrap, env});
            rd(8'h10, 32'h0);
            check("pinAlloc", pinAlloc, {env != 0, env != 0, env == 2});
            check("clkOut", clkOut, env != 0);
            check("bootFromRom", bootFromRom, env == 0);
            ws = rnd[3:0];
            vis = rnd[4];
            ctrl = {1'b1, vis, s[0], s[1], ws};
            wr(`BES_CTRL_OFS, ctrl);
            rd(`BES_CTRL_OFS, ctrl);
            repeat (2) @(posedge clk);
            #1;
            check("bus16", bus16, s[1]);
            check("clkOut", clkOut, 1'b1);
            baseAccessStart <= 1'b1;
            @(posedge clk);
            baseAccessStart <= 1'b0;
            n = 0;
            while (!baseAccessDone && n < 40) begin
                @(posedge clk);
                #1;
                n++;
            end
            check("accessCycles", n, ws + 1);
            for (int i = 0; i < 3; i++) begin
                fetchAddr <= (i == 0) ? 17'h0_07FF :
                    (i == 1) ? 17'h0_0800 : 17'h1_8000;
                repeat (2) @(posedge clk);
                #1;
                check("decode", {selRom, selBase, selApp},
                    {i == 0 && env == 0, i < 2 && env != 0, i == 2 && s[0]});
            end
            run <= 1'b1;
            stOn <= 1'b1;
            repeat (30) @(posedge clk);
            run <= 1'b0;
            repeat (2) @(posedge clk);
            stOn <= 1'b0;
            // Flush only once the monitor has stopped pushing
            @(posedge clk);
            stQ.delete();
            straps <= ~s[1:0];
            hdStrap <= ~s[0];
            pulse(0);
            check("hostEn", hostEn, 1'b1);
            pulse(1);
            check("hostEn", hostEn, s[0]);
            rd(`BES_CTRL_OFS, 32'h0);
            pulse(2);
            rd(`BES_STAT_OFS, {28'h0, s[0], s[0], env});
            wr(`BES_BOOT_OFS, 32'h1);
            repeat (3) @(posedge clk);
            #1;
            check("hostReprog", {hostReprog, runApp}, 2'b10);
            wr(`BES_BOOT_OFS, 32'h3);
            repeat (3) @(posedge clk);
            #1;
            check("runApp", {runApp, bootFromRom}, 2'b10);
            rd(`BES_STAT_OFS, {26'h0, 2'h1, s[0], s[0], env});
            repeat (3) @(posedge clk);
        end
        test_done();
    end
endmodule
`default_nettype wire
